// File: core/capability_regs.sv
// Port and power-management capability registers behind an AXI4-Lite slave
//
// What this block does
// - Status top byte reads four outstanding requests
// - Status sideband support bit reads zero
// - Status supported rates field reads binary 11
// - Command sideband switch reads zero, ignores writes
// - Master gate bit, reset zero, allows master operations
// - Rate select resets zero; one single, two double
// - Power capability version reads constant one
// - Next offset zero or 0x44 per strap
// - Power capability identifier reads constant one
// - Power state read-write, resets zero, D0/D3hot
// - Power state changes only stored value
// - Write zero or hard reset returns D0
// - Port entry identifier two, null next offset
//
// The AXI4-Lite interface to the registers was decided locally.
`default_nettype none
module capability_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Interface strap, sampled after reset release: 1 selects the port interface
  input wire logic port_strap,
  // Master request from the transfer engine
  input wire logic master_request,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Configuration seen by the rest of the device
  output logic master_start,
  output logic [2:0] rate_select,
  output logic [7:0] request_depth_setting,
  output logic [1:0] power_state
);

  // Writable state
  cap_regs_pkg::port_command_t command_reg;
  cap_regs_pkg::port_command_t command_next;
  logic [1:0] power_state_reg;
  logic [1:0] power_state_next;
  logic strap_taken_reg;
  logic strap_taken_next;
  logic port_mode_reg;
  logic port_mode_next;

  // Write channel state
  logic aw_held_reg;
  logic aw_held_next;
  logic [7:0] aw_addr_reg;
  logic [7:0] aw_addr_next;
  logic w_held_reg;
  logic w_held_next;
  logic [31:0] w_data_reg;
  logic [31:0] w_data_next;
  logic [3:0] w_strb_reg;
  logic [3:0] w_strb_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;

  // Read channel state
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;

  logic do_write;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [31:0] read_word;
  logic read_hit;

  // Handshake outputs
  // New requests wait while an answer is still pending
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Device-facing outputs; power state has no effect on operation
  assign master_start = master_request && command_reg.master_operation_gate;
  assign rate_select = command_reg.rate_select;
  assign request_depth_setting = command_reg.request_depth_setting;
  assign power_state = power_state_reg;

  // Write joins address and data, whichever arrives first
  always_comb begin
    wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
    wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
    do_write = !bvalid_reg && (aw_held_reg || s_axi_awvalid) && (w_held_reg || s_axi_wvalid);
    unique case ({wr_addr[7:2], 2'b00})
      cap_regs_pkg::OFF_PORT_CAP,
      cap_regs_pkg::OFF_PORT_STATUS,
      cap_regs_pkg::OFF_PORT_COMMAND,
      cap_regs_pkg::OFF_POWER_CAP,
      cap_regs_pkg::OFF_POWER_CTRL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Write channel and register updates
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    command_next = command_reg;
    power_state_next = power_state_reg;
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? cap_regs_pkg::RESP_OKAY : cap_regs_pkg::RESP_SLVERR;
      // Only writable fields change; the sideband switch stays zero
      if ({wr_addr[7:2], 2'b00} == cap_regs_pkg::OFF_PORT_COMMAND) begin
        if (wr_strb[3]) begin
          command_next.request_depth_setting = wr_data[31:24];
        end
        if (wr_strb[1]) begin
          command_next.master_operation_gate = wr_data[8];
        end
        if (wr_strb[0]) begin
          command_next.rate_select = wr_data[2:0];
        end
      end
      // Any two-bit code is stored; writing zero returns to D0
      if ({wr_addr[7:2], 2'b00} == cap_regs_pkg::OFF_POWER_CTRL && wr_strb[0]) begin
        power_state_next = wr_data[1:0];
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_next = 1'b1;
        aw_addr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_next = 1'b1;
        w_data_next = s_axi_wdata;
        w_strb_next = s_axi_wstrb;
      end
    end
  end

  // Strap capture once after reset release
  // Held until the next reset; later strap changes are ignored
  // so the list link cannot move under running software
  always_comb begin
    strap_taken_next = 1'b1;
    port_mode_next = strap_taken_reg ? port_mode_reg : port_strap;
  end

  // Read decode; reserved bits are zero
  always_comb begin
    read_word = 32'h0000_0000;
    read_hit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      cap_regs_pkg::OFF_PORT_CAP: begin
        read_word[23:20] = cap_regs_pkg::PORT_CAP_MAJOR;
        read_word[19:16] = cap_regs_pkg::PORT_CAP_MINOR;
        read_word[15:8] = cap_regs_pkg::NULL_OFFSET;
        read_word[7:0] = cap_regs_pkg::PORT_CAP_IDENTIFIER;
      end
      cap_regs_pkg::OFF_PORT_STATUS: begin
        read_word[31:24] = cap_regs_pkg::MAX_OUTSTANDING_REQUESTS;
        read_word[9] = 1'b0;
        read_word[1:0] = cap_regs_pkg::SUPPORTED_RATES;
      end
      cap_regs_pkg::OFF_PORT_COMMAND: begin
        read_word[31:24] = command_reg.request_depth_setting;
        read_word[9] = 1'b0;
        read_word[8] = command_reg.master_operation_gate;
        read_word[2:0] = command_reg.rate_select;
      end
      cap_regs_pkg::OFF_POWER_CAP: begin
        read_word[18:16] = cap_regs_pkg::POWER_VERSION;
        read_word[15:8] = port_mode_reg ? cap_regs_pkg::OFF_PORT_CAP
                                        : cap_regs_pkg::NULL_OFFSET;
        read_word[7:0] = cap_regs_pkg::POWER_CAP_IDENTIFIER;
      end
      cap_regs_pkg::OFF_POWER_CTRL: begin
        read_word[1:0] = power_state_reg;
      end
      default: begin
        read_hit = 1'b0;
      end
    endcase
  end

  // Read channel
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rdata_next = read_word;
      rresp_next = read_hit ? cap_regs_pkg::RESP_OKAY : cap_regs_pkg::RESP_SLVERR;
    end
  end

  // Command and power state; hard bus reset clears both
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      command_reg.request_depth_setting <= cap_regs_pkg::REQUEST_DEPTH_RESET;
      command_reg.master_operation_gate <= 1'b0;
      command_reg.rate_select <= cap_regs_pkg::RATE_RESET;
      power_state_reg <= cap_regs_pkg::POWER_STATE_RESET;
    end else begin
      command_reg <= command_next;
      power_state_reg <= power_state_next;
    end
  end

  // Strap capture registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken_reg <= 1'b0;
      port_mode_reg <= 1'b0;
    end else begin
      strap_taken_reg <= strap_taken_next;
      port_mode_reg <= port_mode_next;
    end
  end

  // Write channel registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= cap_regs_pkg::RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // Read channel registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= cap_regs_pkg::RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

endmodule : capability_regs
`default_nettype wire

// File: pkg/cap_regs_pkg.sv
// Package: offsets, field layouts and reset values of the capability registers
`default_nettype none
package cap_regs_pkg;
  // Byte offsets
  localparam logic [7:0] OFF_PORT_CAP = 8'h44;
  localparam logic [7:0] OFF_PORT_STATUS = 8'h48;
  localparam logic [7:0] OFF_PORT_COMMAND = 8'h4C;
  localparam logic [7:0] OFF_POWER_CAP = 8'h60;
  localparam logic [7:0] OFF_POWER_CTRL = 8'h64;
  // Constant field values
  localparam logic [7:0] MAX_OUTSTANDING_REQUESTS = 8'h04;
  localparam logic [1:0] SUPPORTED_RATES = 2'h3;
  localparam logic [7:0] PORT_CAP_IDENTIFIER = 8'h02;
  localparam logic [3:0] PORT_CAP_MAJOR = 4'h1;
  localparam logic [3:0] PORT_CAP_MINOR = 4'h0;
  localparam logic [7:0] POWER_CAP_IDENTIFIER = 8'h01;
  localparam logic [2:0] POWER_VERSION = 3'h1;
  localparam logic [7:0] NULL_OFFSET = 8'h00;
  // Reset values
  localparam logic [7:0] REQUEST_DEPTH_RESET = 8'h00;
  localparam logic [2:0] RATE_RESET = 3'h0;
  localparam logic [1:0] POWER_STATE_RESET = 2'h0;
  // Rate and power state codes
  localparam logic [2:0] RATE_PLAIN_BUS = 3'h0;
  localparam logic [2:0] RATE_SINGLE = 3'h1;
  localparam logic [2:0] RATE_DOUBLE = 3'h2;
  localparam logic [1:0] STATE_D0 = 2'h0;
  localparam logic [1:0] STATE_D3HOT = 2'h3;
  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Writable command fields
  typedef struct packed {
    logic [7:0] request_depth_setting;
    logic master_operation_gate;
    logic [2:0] rate_select;
  } port_command_t;
endpackage : cap_regs_pkg
`default_nettype wire

// File: sim/capability_regs_chk.sv
// Checker: handshake and field properties at the capability register ports
`default_nettype none
module capability_regs_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Master path
  input wire logic master_request,
  input wire logic master_start,
  // Bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Configuration outputs
  input wire logic [2:0] rate_select,
  input wire logic [1:0] power_state
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Properties
  gate_follow_a: assert property (master_start |-> master_request)
    else $error("master start without request");
  gate_hold_a: assert property ($past(master_request) && master_request &&
    !$rose(s_axi_bvalid) |-> $stable(master_start))
    else $error("master start moved without a write");
  power_write_a: assert property (!$stable(power_state) |-> $rose(s_axi_bvalid))
    else $error("power state moved without a write");
  rate_write_a: assert property (!$stable(rate_select) |-> $rose(s_axi_bvalid))
    else $error("rate moved without a write");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not retired");
  write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not retired");
  reserved_zero_a: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'h0000BAF8) == 32'h0)
    else $error("reserved read bits set");
endmodule : capability_regs_chk
`default_nettype wire

// File: sim/host_bridge_model.sv
// Host bridge model: bus master issuing configuration reads and writes
`default_nettype none
module host_bridge_model (
  // Clock
  input wire logic core_clk,
  // Write channels
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Read channels
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
  end
  // Write: both channels offered, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // Read: address held until taken, answer awaited
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : host_bridge_model
`default_nettype wire

// File: sim/capability_regs_tb.sv
// Testbench: register map, field access and reset of the capability registers
`default_nettype none
module capability_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_n, port_strap, master_request, master_start;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, request_depth_setting;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, power_state, rsp;
  logic [2:0] rate_select;
  int error_cnt = 0;
  int comparisons = 0;
  // Design and host
  capability_regs dut (.core_clk, .rst_n, .port_strap, .master_request, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .master_start, .rate_select,
    .request_depth_setting, .power_state);
  host_bridge_model host (.core_clk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  // Clock, 40 ns period
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Read with OKAY expected
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    host.rd(a, rd_data, rsp);
    chk(rd_data, exp);
    chk({30'h0, rsp}, {30'h0, cap_regs_pkg::RESP_OKAY});
  endtask : rdc
  // Write with OKAY expected
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    host.wr(a, d, s, rsp);
    chk({30'h0, rsp}, {30'h0, cap_regs_pkg::RESP_OKAY});
  endtask : wrc
  // Five-cycle reset
  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask : reset_dut
  // Verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  // Watchdog
  initial begin
    repeat (3000) @(posedge core_clk);
    error_cnt++;
    complete_run();
  end
  // Test sequence
  initial begin
    rst_n = 1'b0;
    port_strap = 1'b0;
    master_request = 1'b0;
    reset_dut();
    rdc(8'h48, 32'h0400_0003);
    rdc(8'h44, 32'h0010_0002);
    rdc(8'h60, 32'h0001_0001);
    rdc(8'h4C, 32'h0000_0000);
    rdc(8'h64, 32'h0000_0000);
    host.rd(8'h50, rd_data, rsp);
    chk({30'h0, rsp}, {30'h0, cap_regs_pkg::RESP_SLVERR});
    chk(rd_data, 32'h0000_0000);
    host.wr(8'h50, 32'hFFFF_FFFF, 4'hF, rsp);
    chk({30'h0, rsp}, {30'h0, cap_regs_pkg::RESP_SLVERR});
    wrc(8'h48, 32'hFFFF_FFFF, 4'hF);
    rdc(8'h48, 32'h0400_0003);
    master_request <= 1'b1;
    @(negedge core_clk);
    chk({31'h0, master_start}, 32'h0);
    wrc(8'h4C, 32'h0000_0002, 4'h1);
    wrc(8'h4C, 32'h0800_0302, 4'hF);
    rdc(8'h4C, 32'h0800_0102);
    @(negedge core_clk);
    chk({31'h0, master_start}, 32'h1);
    chk({29'h0, rate_select}, {29'h0, cap_regs_pkg::RATE_DOUBLE});
    chk({24'h0, request_depth_setting}, 32'h8);
    wrc(8'h4C, 32'hFF00_0001, 4'h1);
    rdc(8'h4C, 32'h0800_0101);
    chk({29'h0, rate_select}, {29'h0, cap_regs_pkg::RATE_SINGLE});
    master_request <= 1'b0;
    @(negedge core_clk);
    chk({31'h0, master_start}, 32'h0);
    wrc(8'h4D, 32'h0000_0000, 4'h2);
    rdc(8'h4C, 32'h0800_0001);
    wrc(8'h64, 32'hFFFF_FFFF, 4'hF);
    rdc(8'h64, 32'h0000_0003);
    chk({30'h0, power_state}, {30'h0, cap_regs_pkg::STATE_D3HOT});
    wrc(8'h64, 32'h0000_0000, 4'h1);
    rdc(8'h64, 32'h0000_0000);
    wrc(8'h64, 32'h0000_0003, 4'h1);
    port_strap <= 1'b1;
    reset_dut();
    @(negedge core_clk);
    chk({30'h0, power_state}, {30'h0, cap_regs_pkg::STATE_D0});
    rdc(8'h60, 32'h0001_4401);
    rdc(8'h4C, 32'h0000_0000);
    complete_run();
  end
endmodule : capability_regs_tb
bind capability_regs capability_regs_chk chk (.core_clk, .rst_n, .master_request,
  .master_start, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_bvalid, .s_axi_bready, .rate_select, .power_state);
`default_nettype wire
